/* design/dst_pkg.sv */
/*
 dst_pkg: types and the vote function of the trip voting block.
 assumes nothing of its surroundings.
*/
`default_nettype none
package dst_pkg;
    typedef enum logic [1:0] {GRP_RUN, GRP_OFF, GRP_STAGE} dst_grp_e;

    function automatic logic dst_two(input logic [3:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[0] & v[3]) |
               (v[1] & v[2]) | (v[1] & v[3]) | (v[2] & v[3]);
    endfunction
endpackage // dst_pkg
`default_nettype wire

/* design/dst_pool.sv */
/*
 dst_pool: pool temperature channels from a thermocouple stream.
 assumes each channel's 16 samples arrive in index order 0..15 on clk.
*/
`default_nettype none
`include "dst_regs.svh"
module dst_pool (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        tc_valid,
    input  wire logic [1:0]  tc_ch,
    input  wire logic [3:0]  tc_idx,
    input  wire logic [11:0] tc_data,
    input  wire logic        tc_ok,
    input  wire logic [15:0] submerged,
    input  wire logic [11:0] limit,
    output logic      [3:0]  hi
);
    logic [15:0] sum;
    logic [15:0] next_sum;
    logic [4:0]  nsub;
    logic [4:0]  next_nsub;
    logic [4:0]  nok;
    logic [4:0]  next_nok;
    logic [3:0]  next_hi;

    always_comb begin
        next_sum = sum;
        next_nsub = nsub;
        next_nok = nok;
        next_hi = hi;
        if (tc_valid) begin
            if (tc_idx == 4'h0) begin
                next_sum = 16'h0000;
                next_nsub = 5'h00;
                next_nok = 5'h00;
            end
            if (tc_ok && submerged[tc_idx]) begin
                next_sum = next_sum + {4'h0, tc_data};
                next_nsub = next_nsub + 5'h01;
            end
            if (tc_ok) begin
                next_nok = next_nok + 5'h01;
            end
            // average above limit, without a divider: sum > limit * n
            if (tc_idx == 4'hF) begin
                next_hi[tc_ch] = (next_nok >= `DST_TC_MIN_OK) &&
                    (next_nsub != 5'h00) &&
                    ({1'b0, next_sum} >
                     ({5'h00, limit} * {12'h000, next_nsub}));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sum <= 16'h0000;
            nsub <= 5'h00;
            nok <= 5'h00;
            hi <= 4'h0;
        end else if (ce) begin
            sum <= next_sum;
            nsub <= next_nsub;
            nok <= next_nok;
            hi <= next_hi;
        end
    end

    a_tc_quorum: assert property (
        @(posedge clk) disable iff (rst || !ce)
        (tc_valid && tc_idx == 4'hF && next_nok < `DST_TC_MIN_OK)
        |=> !hi[$past(tc_ch)])
        else $error("pool high flagged with too few thermocouples");
endmodule // dst_pool
`default_nettype wire

/* design/dst_regs.svh */
/*
 dst_regs.svh: register offsets, field positions, reset values and
 timing counts of the divisional trip voting block.
 assumes the system clock runs at 50 MHz.
*/
`ifndef DST_REGS_SVH
`define DST_REGS_SVH
`define DST_CLK_KHZ     50000
`define DST_A_LIM       8'h00
`define DST_A_BYP       8'h04
`define DST_A_STAT      8'h08
`define DST_A_SRC       8'h0C
`define DST_LIM_RST     12'h0320
`define DST_BYP_RST     2'h0
`define DST_BYP_COND    0
`define DST_BYP_BUS     1
`define DST_TC_MIN_OK   5'h0C
`define DST_BYP_WIN_MS  100
`define DST_BUS_DLY_MS  500
`define DST_RST_BLK_MS  10000
`define DST_STAGGER_MS  100
`define DST_BYP_WIN_CYC (`DST_BYP_WIN_MS * `DST_CLK_KHZ)
`define DST_BUS_DLY_CYC (`DST_BUS_DLY_MS * `DST_CLK_KHZ)
`define DST_RST_BLK_CYC (`DST_RST_BLK_MS * `DST_CLK_KHZ)
`define DST_STAGGER_CYC (`DST_STAGGER_MS * `DST_CLK_KHZ)
`endif

/* design/dst_tmr.sv */
/*
 dst_tmr: counts while run is high, done once LIM cycles have passed.
 assumes LIM is at least one; dropping run restarts the count.
*/
`default_nettype none
module dst_tmr #(
    parameter int unsigned LIM = 1
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    dst_tmr_if.tmr    t
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;

    always_comb begin
        next_cnt = 32'h0000_0000;
        if (t.run) begin
            next_cnt = (cnt == LIM) ? cnt : cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 32'h0000_0000;
        end else if (ce) begin
            cnt <= next_cnt;
        end
    end

    // done follows run at once, so a vote that drops cannot trip late
    assign t.done = (cnt == LIM) && t.run;
endmodule // dst_tmr
`default_nettype wire

/* design/dst_tmr_if.sv */
/*
 dst_tmr_if: run request and expiry of one delay timer.
 assumes the controller and timer share one clock.
*/
`default_nettype none
interface dst_tmr_if;
    logic run;
    logic done;
    modport ctl (output run, input done);
    modport tmr (input run, output done);
endinterface // dst_tmr_if
`default_nettype wire

/* design/dst_top.sv */
/*
 dst_top: divisional trip voting, manual scram, reset and seal-in,
 with a wishbone classic register slave.
 assumes switch and sensor pins are asynchronous; the thermocouple
 stream, the level mask and the bus master run on CLK.
*/
`default_nettype none
`include "dst_regs.svh"
// Function
// - each division trips when two of four stop valves read closed
// - each division trips when two of four oil channels read low
// - bypass valves open within the window inhibit valve closure trips
// - bypass permissive is a two-of-four vote of divisional contacts
// - in run mode two-of-four bus low voltage starts delayed scram
// - bus loss delay is a preset under one second
// - mode switch in shutdown drops both manual groups: full scram
// - full manual scram needs both manual switches, one per group
// - a manual group out of service gives half scram
// - manual scram acts only through groups one and two
// - divisional manual switch trips its division; two give scram
// - trips seal in; divisional and common manual resets clear them
// - reset ignored while the cause of the trip remains
// - all manual resets blocked for ten seconds after a scram
// - groups re-energise one at a time after reset
// - low header pressure blocks divisional reset until bypassed in all four
// - pool channel temperature is the average of sixteen sensors
// - pool high is valid only with twelve operable sensors
// - pool high in two of four channels trips
// - sensors above water level are left out of the average
// - high condenser pressure trips each division
// - two automatic division trips or both manual groups cut power
module dst_top #(
    parameter int unsigned BYP_WIN_CYC = `DST_BYP_WIN_CYC,
    parameter int unsigned BUS_DLY_CYC = `DST_BUS_DLY_CYC,
    parameter int unsigned RST_BLK_CYC = `DST_RST_BLK_CYC,
    parameter int unsigned STAGGER_CYC = `DST_STAGGER_CYC
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CE,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [31:0] DAT_I,
    input  wire logic        WE_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    output var  logic [31:0] DAT_O,
    output var  logic        ACK_O,
    input  wire logic [3:0]  STOP_VALVE_CLOSED,
    input  wire logic [3:0]  CV_LOW_OIL,
    input  wire logic [3:0]  BYPASS_VALVE_OPEN,
    input  wire logic [3:0]  COND_PRESS_HI,
    input  wire logic [3:0]  BUS_LOW_VOLT,
    input  wire logic [3:0]  HDR_PRESS_LOW,
    input  wire logic [3:0]  HDR_TRIP_BYPASS,
    input  wire logic [3:0]  DIV_MAN_TRIP,
    input  wire logic [3:0]  DIV_RESET,
    input  wire logic [1:0]  MAN_SCRAM_PB,
    input  wire logic [1:0]  MAN_DIV_OOS,
    input  wire logic        MAN_RESET,
    input  wire logic        MODE_SHUTDOWN,
    input  wire logic        MODE_RUN,
    input  wire logic        TC_VALID,
    input  wire logic [1:0]  TC_CH,
    input  wire logic [3:0]  TC_IDX,
    input  wire logic [11:0] TC_DATA,
    input  wire logic        TC_OK,
    input  wire logic [15:0] POOL_SUBMERGED,
    output var  logic [1:0]  SCRAM_GRP_PWR,
    output var  logic [3:0]  DIV_TRIP,
    output var  logic        FULL_SCRAM,
    output var  logic        HALF_SCRAM,
    output var  logic        RESET_BLOCKED
);
    logic [42:0] s1;
    logic [42:0] s2;
    logic [3:0]  svc;
    logic [3:0]  cvl;
    logic [3:0]  bvo;
    logic [3:0]  cph;
    logic [3:0]  blv;
    logic [3:0]  hpl;
    logic [3:0]  hbp;
    logic [3:0]  dmt;
    logic [3:0]  drs;
    logic [1:0]  mpb;
    logic [1:0]  moos;
    logic        mrs;
    logic        msd;
    logic        mrn;
    logic        sv_v;
    logic        cv_v;
    logic        perm;
    logic        turb;
    logic        bus_t;
    logic        pool_t;
    logic        hdr_hold;
    logic        alt;
    logic        auto_t;
    logic        full;
    logic [3:0]  pool_hi;
    logic [3:0]  cond_t;
    logic [3:0]  cause;
    logic [3:0]  next_div;
    logic [1:0]  man;
    logic [1:0]  next_man;
    logic [1:0]  man_cause;
    logic [1:0]  man_off;
    logic [1:0]  next_pwr;
    logic        next_half;
    logic        next_blk;
    logic [11:0] lim;
    logic [11:0] next_lim;
    logic [1:0]  byp;
    logic [1:0]  next_byp;
    logic        next_ack;
    logic [31:0] next_dat;
    dst_pkg::dst_grp_e grp;
    dst_pkg::dst_grp_e next_grp;

    dst_tmr_if win_if ();
    dst_tmr_if bus_if ();
    dst_tmr_if blk_if ();
    dst_tmr_if stg_if ();

    dst_tmr #(.LIM(BYP_WIN_CYC)) u_win (
        .clk (CLK), .rst (SYS_RST), .ce (CE), .t (win_if.tmr));
    dst_tmr #(.LIM(BUS_DLY_CYC)) u_bus (
        .clk (CLK), .rst (SYS_RST), .ce (CE), .t (bus_if.tmr));
    dst_tmr #(.LIM(RST_BLK_CYC)) u_blk (
        .clk (CLK), .rst (SYS_RST), .ce (CE), .t (blk_if.tmr));
    dst_tmr #(.LIM(STAGGER_CYC)) u_stg (
        .clk (CLK), .rst (SYS_RST), .ce (CE), .t (stg_if.tmr));

    dst_pool u_pool (
        .clk       (CLK),
        .rst       (SYS_RST),
        .ce        (CE),
        .tc_valid  (TC_VALID),
        .tc_ch     (TC_CH),
        .tc_idx    (TC_IDX),
        .tc_data   (TC_DATA),
        .tc_ok     (TC_OK),
        .submerged (POOL_SUBMERGED),
        .limit     (lim),
        .hi        (pool_hi)
    );

    // every field pin is asynchronous: two flops before any use, except MAN_RESET, which the manual reset reads raw
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s1 <= 43'h000_0000_0000;
            s2 <= 43'h000_0000_0000;
        end else if (CE) begin
            s1 <= {STOP_VALVE_CLOSED, CV_LOW_OIL, BYPASS_VALVE_OPEN,
                   COND_PRESS_HI, BUS_LOW_VOLT, HDR_PRESS_LOW,
                   HDR_TRIP_BYPASS, DIV_MAN_TRIP, DIV_RESET,
                   MAN_SCRAM_PB, MAN_DIV_OOS, MAN_RESET,
                   MODE_SHUTDOWN, MODE_RUN};
            s2 <= s1;
        end
    end

    assign {svc, cvl, bvo, cph, blv, hpl, hbp, dmt, drs,
            mpb, moos, mrs, msd, mrn} = s2;

    // valve closure arms the window; trip only if bypass stays shut
    assign win_if.run = sv_v | cv_v;
    // a bus that recovers before expiry drops run and clears the count
    assign bus_if.run = mrn & dst_pkg::dst_two(blv)
                        & ~byp[`DST_BYP_BUS];
    assign blk_if.run = RESET_BLOCKED;
    assign stg_if.run = (grp == dst_pkg::GRP_STAGE);

    always_comb begin
        sv_v = dst_pkg::dst_two(svc);
        cv_v = dst_pkg::dst_two(cvl);
        perm = dst_pkg::dst_two(bvo);
        turb = win_if.done & ~perm;
        bus_t = bus_if.done;
        pool_t = dst_pkg::dst_two(pool_hi);
        cond_t = cph & {4{~byp[`DST_BYP_COND]}};
        hdr_hold = (|hpl) & ~(&hbp);
        cause = {4{turb | bus_t | pool_t}} | cond_t
                | (hpl & ~hbp) | dmt;
        next_div = DIV_TRIP | cause;
        if (!RESET_BLOCKED && !hdr_hold) begin
            next_div = next_div & ~(drs & ~cause);
        end

        // only the two load power groups carry the manual path
        man_cause = mpb | {2{msd}};
        next_man = man | man_cause;
        if (MAN_RESET && !RESET_BLOCKED) begin
            next_man = man_cause;
        end
        man_off = man | moos;
        alt = dst_pkg::dst_two(dmt);
        auto_t = dst_pkg::dst_two(DIV_TRIP);
        full = auto_t | (&man_off) | alt;
        next_half = (|man_off) & ~full;

        next_blk = RESET_BLOCKED;
        if (full && !FULL_SCRAM) begin
            next_blk = 1'b1;
        end else if (blk_if.done) begin
            next_blk = 1'b0;
        end

        next_grp = grp;
        unique case (grp)
            dst_pkg::GRP_RUN: begin
                if (full) next_grp = dst_pkg::GRP_OFF;
            end
            dst_pkg::GRP_OFF: begin
                if (!full) next_grp = dst_pkg::GRP_STAGE;
            end
            dst_pkg::GRP_STAGE: begin
                if (full) next_grp = dst_pkg::GRP_OFF;
                else if (stg_if.done) next_grp = dst_pkg::GRP_RUN;
            end
            default: next_grp = dst_pkg::GRP_OFF;
        endcase
        // half the solenoids first, the other half after the stagger
        unique case (next_grp)
            dst_pkg::GRP_RUN:   next_pwr = ~man_off;
            dst_pkg::GRP_OFF:   next_pwr = 2'h0;
            dst_pkg::GRP_STAGE: next_pwr = {1'b0, ~man_off[0]};
            default:            next_pwr = 2'h0;
        endcase
    end

    always_comb begin
        next_ack = CYC_I & STB_I & ~ACK_O;
        next_lim = lim;
        next_byp = byp;
        next_dat = 32'h0000_0000;
        if (next_ack && WE_I) begin
            if (ADR_I == `DST_A_LIM && SEL_I[0]) begin
                next_lim[7:0] = DAT_I[7:0];
            end
            if (ADR_I == `DST_A_LIM && SEL_I[1]) begin
                next_lim[11:8] = DAT_I[11:8];
            end
            if (ADR_I == `DST_A_BYP && SEL_I[0]) begin
                next_byp = DAT_I[1:0];
            end
        end else if (next_ack) begin
            case (ADR_I)
                `DST_A_LIM:  next_dat = {20'h0_0000, lim};
                `DST_A_BYP:  next_dat = {30'h0000_0000, byp};
                `DST_A_STAT: next_dat = {21'h00_0000, RESET_BLOCKED,
                                         HALF_SCRAM, FULL_SCRAM,
                                         SCRAM_GRP_PWR, man, DIV_TRIP};
                `DST_A_SRC:  next_dat = {22'h00_0000, pool_hi, pool_t,
                                         bus_t, turb, perm, cv_v, sv_v};
                default:     next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            DIV_TRIP <= 4'h0;
            man <= 2'h0;
            grp <= dst_pkg::GRP_OFF;
            SCRAM_GRP_PWR <= 2'h0;
            FULL_SCRAM <= 1'b0;
            HALF_SCRAM <= 1'b0;
            RESET_BLOCKED <= 1'b0;
            lim <= `DST_LIM_RST;
            byp <= `DST_BYP_RST;
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else if (CE) begin
            DIV_TRIP <= next_div;
            man <= next_man;
            grp <= next_grp;
            SCRAM_GRP_PWR <= next_pwr;
            FULL_SCRAM <= full;
            HALF_SCRAM <= next_half;
            RESET_BLOCKED <= next_blk;
            lim <= next_lim;
            byp <= next_byp;
            ACK_O <= next_ack;
            DAT_O <= next_dat;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST || !CE);

    a_turb_trip: assert property (
        turb |=> &DIV_TRIP)
        else $error("turbine trip not sealed in all divisions");
    a_turb_cause: assert property (
        turb |-> (sv_v || cv_v) && win_if.done)
        else $error("turbine trip without valve vote");
    a_byp_inhibit: assert property (
        perm |-> !turb)
        else $error("turbine trip despite bypass permissive");
    a_bus_wait: assert property (
        $rose(bus_if.run) |=> !bus_t)
        else $error("bus loss trip without delay");
    a_bus_cancel: assert property (
        !bus_if.run |=> !bus_t)
        else $error("bus loss trip after voltage returned");
    a_mode_sd: assert property (
        msd |-> ##2 FULL_SCRAM)
        else $error("shutdown position gave no full scram");
    a_man_both: assert property (
        (&man_off) |=> SCRAM_GRP_PWR == 2'h0 && FULL_SCRAM)
        else $error("both manual groups off but power kept");
    a_half_scram: assert property (
        (^man_off && !auto_t && !alt) |=> HALF_SCRAM && !FULL_SCRAM)
        else $error("single manual group did not give half scram");
    a_reset_cause: assert property (
        1'b1 |=> (DIV_TRIP & $past(cause)) == $past(cause))
        else $error("division trip cleared with cause present");
    a_reset_block: assert property (
        RESET_BLOCKED |=> ($past(DIV_TRIP) & ~DIV_TRIP) == 4'h0)
        else $error("division reset during block time");
    a_stage_half: assert property (
        grp == dst_pkg::GRP_STAGE |-> !SCRAM_GRP_PWR[1])
        else $error("both groups powered during stagger");
    a_no_jump: assert property (
        grp == dst_pkg::GRP_OFF |=> grp != dst_pkg::GRP_RUN)
        else $error("groups re-energised without stagger");
    a_hdr_hold: assert property (
        hdr_hold |=> ($past(DIV_TRIP) & ~DIV_TRIP) == 4'h0)
        else $error("reset while header low not bypassed");
    a_pool_vote: assert property (
        pool_t |=> &DIV_TRIP)
        else $error("pool high vote did not trip");
    a_cond_trip: assert property (
        cond_t[0] |=> DIV_TRIP[0])
        else $error("condenser pressure did not trip division");
    a_auto_scram: assert property (
        auto_t |=> FULL_SCRAM && SCRAM_GRP_PWR == 2'h0)
        else $error("two division trips did not cut power");

    c_turb_inhibit: cover property (cv_v && perm);
    c_bus_trip: cover property (bus_t);
    c_stagger: cover property (grp == dst_pkg::GRP_STAGE
                               ##1 grp == dst_pkg::GRP_RUN);
endmodule // dst_top
`default_nettype wire

/* testbench/dst_plant.sv */
/*
 dst_plant: plant side model, thermocouple stream and accumulator header.
 assumes it shares the block clock; the bench calls send for samples.
*/
`default_nettype none
module dst_plant (
    input  wire logic        clk,
    input  wire logic [1:0]  grp_pwr,
    output logic             tc_valid,
    output logic      [1:0]  tc_ch,
    output logic      [3:0]  tc_idx,
    output logic      [11:0] tc_data,
    output logic             tc_ok,
    output logic      [3:0]  hdr_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] lag = 3'h0;

    initial begin
        tc_valid = 1'h0;
        tc_ch    = 2'h0;
        tc_idx   = 4'h0;
        tc_data  = 12'h000;
        tc_ok    = 1'h0;
        hdr_low  = 4'hF;
    end

    // header bleeds down once all solenoids drop and refills slowly
    always @(posedge clk) begin
        lag     <= (grp_pwr == 2'h0) ? 3'h0 : lag + 3'(lag != 3'h7);
        hdr_low <= (lag == 3'h7) ? 4'h0 : 4'hF;
    end

    task automatic send(input logic [1:0] ch, input logic [11:0] top,
                        input logic [11:0] rest, input int nbad);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            tc_valid <= 1'h1;
            tc_ch    <= ch;
            tc_idx   <= 4'(i);
            tc_data  <= (i < 4) ? top : rest;
            tc_ok    <= (i >= nbad);
        end
        @(posedge clk);
        tc_valid <= 1'h0;
        tc_data  <= ~rest;
        tc_ok    <= ~tc_ok;
    endtask
endmodule // dst_plant
`default_nettype wire

/* testbench/dst_top_tb.sv */
/*
 dst_top_tb: self-checking bench of the divisional trip voting block.
 assumes shortened timing parameters and the plant model beside it.
*/
`default_nettype none
module dst_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned BLK = 40;
    logic        clk = 1'h0, sys_rst = 1'h1, ce = 1'h1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [3:0]  sel = 4'h0;
    logic        wr = 1'h0, cyc = 1'h0, stb = 1'h0;
    logic [3:0]  sv = 4'h0, oil = 4'h0, byp = 4'h0, cond = 4'h0;
    logic [3:0]  bus = 4'h0, hbyp = 4'hF, dman = 4'h0, drst = 4'h0;
    logic [1:0]  pb = 2'h0, oos = 2'h0;
    logic        mrst = 1'h0, mshut = 1'h0, mrun = 1'h1;
    logic [31:0] dat_o, rd;
    logic        ack, full, half, blkd, control_valve_fast_close, tcok;
    logic [1:0]  pwr, tcch;
    logic [3:0]  dtrip, hlow, tcidx;
    logic [11:0] tcdat;
    int          err_count = 0, comparisons = 0;
    wire  [8:0]  obs = {blkd, half, full, pwr, dtrip};

    dst_top #(.BYP_WIN_CYC(4), .BUS_DLY_CYC(4), .RST_BLK_CYC(BLK),
              .STAGGER_CYC(8)) dst_top_inst (
        .CLK(clk), .SYS_RST(sys_rst), .CE(ce), .ADR_I(adr),
        .DAT_I(dat_w), .WE_I(wr), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb),
        .DAT_O(dat_o), .ACK_O(ack), .STOP_VALVE_CLOSED(sv),
        .CV_LOW_OIL(oil), .BYPASS_VALVE_OPEN(byp), .COND_PRESS_HI(cond),
        .BUS_LOW_VOLT(bus), .HDR_PRESS_LOW(hlow), .HDR_TRIP_BYPASS(hbyp),
        .DIV_MAN_TRIP(dman), .DIV_RESET(drst), .MAN_SCRAM_PB(pb),
        .MAN_DIV_OOS(oos), .MAN_RESET(mrst), .MODE_SHUTDOWN(mshut),
        .MODE_RUN(mrun), .TC_VALID(control_valve_fast_close), .TC_CH(tcch), .TC_IDX(tcidx),
        .TC_DATA(tcdat), .TC_OK(tcok), .POOL_SUBMERGED(16'hFFF0),
        .SCRAM_GRP_PWR(pwr), .DIV_TRIP(dtrip), .FULL_SCRAM(full),
        .HALF_SCRAM(half), .RESET_BLOCKED(blkd));
    dst_plant dst_plant_inst (.clk(clk), .grp_pwr(pwr), .tc_valid(control_valve_fast_close),
        .tc_ch(tcch), .tc_idx(tcidx), .tc_data(tcdat), .tc_ok(tcok),
        .hdr_low(hlow));

    always #10 clk = ~clk;

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        @(posedge clk);
        cyc   <= 1'h1;
        stb   <= 1'h1;
        adr   <= a;
        wr    <= w;
        sel   <= 4'hF;
        dat_w <= d;
        do @(posedge clk); while (ack !== 1'h1);
        rd = dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask

    // waits a bounded time for the masked outputs, then compares
    task automatic see(input string nm, input logic [8:0] m,
                       input logic [8:0] v, input int n);
        @(negedge clk);
        for (int i = 0; i < n && (obs & m) !== v; i++)
            @(negedge clk);
        chk(nm, {23'h0, obs & m}, {23'h0, v});
        @(posedge clk);
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one cycle of reset switch; k keeps every trip bit seen all along
    task automatic pulse_rst(output logic [3:0] k);
        k = 4'hF;
        drst <= 4'hF;
        repeat (8) begin
            @(negedge clk);
            k = k & dtrip;
            @(posedge clk);
            drst <= 4'h0;
        end
    endtask

    task automatic recover();
        hold(1);
        {sv, oil, byp, cond, bus, dman} <= 24'h0;
        {pb, oos, mshut} <= 5'h0;
        hold(4);
        see("unblock", 9'h100, 9'h000, BLK + 10);
        hold(1);
        hbyp <= 4'hF;
        drst <= 4'hF;
        mrst <= 1'h1;
        hold(1);
        drst <= 4'h0;
        mrst <= 1'h0;
        see("group a", 9'h030, 9'h010, 20);
        see("group b", 9'h030, 9'h030, 12);
        hold(12);
        hbyp <= 4'h0;
        hold(1);
    endtask

    task automatic t_regs();
        wb(8'h00, 1'h0, 32'h0);
        chk("limit", rd, 32'h0000_0320);
        wb(8'h04, 1'h0, 32'h0);
        chk("bypass", rd, 32'h0000_0000);
        wb(8'h10, 1'h0, 32'h0);
        chk("unmapped", rd, 32'h0000_0000);
        wb(8'h00, 1'h1, 32'h0000_0100);
        wb(8'h00, 1'h0, 32'h0);
        chk("limit", rd, 32'h0000_0100);
        wb(8'h08, 1'h1, 32'hFFFF_FFFF);
        wb(8'h08, 1'h0, 32'h0);
        chk("status", rd, 32'h0000_00C0);
        $display("done regs");
    endtask

    task automatic t_stop();
        logic [3:0] k;
        sv <= 4'h9;
        see("stop trip", 9'h07F, 9'h04F, 20);
        see("blocked", 9'h100, 9'h100, 4);
        sv <= 4'h0;
        hbyp <= 4'hF;
        hold(4);
        pulse_rst(k);
        chk("reset blocked", {28'h0, k}, 32'h0000_000F);
        see("unblock", 9'h100, 9'h000, BLK + 10);
        sv <= 4'h3;
        hold(8);
        pulse_rst(k);
        chk("cause kept", {28'h0, k}, 32'h0000_000F);
        sv <= 4'h0;
        hbyp <= 4'h7;
        hold(4);
        pulse_rst(k);
        chk("header kept", {28'h0, k}, 32'h0000_000F);
        recover();
        $display("done stop valve");
    endtask

    task automatic t_cv();
        oil <= 4'h6;
        byp <= 4'h6;
        hold(20);
        see("cv bypassed", 9'h07F, 9'h030, 1);
        oil <= 4'h0;
        byp <= 4'h0;
        hold(6);
        oil <= 4'hC;
        byp <= 4'h4;
        see("cv trip", 9'h07F, 9'h04F, 20);
        recover();
        wb(8'h04, 1'h1, 32'h0000_0001);
        cond <= 4'hF;
        hold(10);
        see("cond bypassed", 9'h07F, 9'h030, 1);
        wb(8'h04, 1'h1, 32'h0000_0000);
        see("cond trip", 9'h07F, 9'h04F, 10);
        recover();
        $display("done valves");
    endtask

    task automatic t_bus();
        mrun <= 1'h0;
        bus <= 4'h3;
        hold(20);
        see("bus not run", 9'h00F, 9'h000, 1);
        bus <= 4'h0;
        mrun <= 1'h1;
        hold(6);
        bus <= 4'h5;
        hold(2);
        bus <= 4'h0;
        hold(20);
        see("bus brief", 9'h00F, 9'h000, 1);
        bus <= 4'hA;
        hold(3);
        see("bus early", 9'h00F, 9'h000, 1);
        see("bus trip", 9'h07F, 9'h04F, 20);
        recover();
        $display("done bus loss");
    endtask

    task automatic t_man();
        pb <= 2'h1;
        hold(10);
        see("one button", 9'h040, 9'h000, 1);
        pb <= 2'h3;
        see("manual", 9'h070, 9'h040, 10);
        recover();
        oos <= 2'h1;
        see("half", 9'h0C0, 9'h080, 10);
        pb <= 2'h2;
        see("half full", 9'h070, 9'h040, 10);
        recover();
        dman <= 4'h1;
        see("div manual", 9'h04F, 9'h001, 10);
        dman <= 4'h3;
        see("div pair", 9'h070, 9'h040, 10);
        recover();
        mshut <= 1'h1;
        see("shutdown", 9'h070, 9'h040, 10);
        recover();
        $display("done manual");
    endtask

    task automatic t_pool();
        dst_plant_inst.send(2'h0, 12'hFFF, 12'h0FF, 0);
        dst_plant_inst.send(2'h1, 12'h101, 12'h101, 0);
        dst_plant_inst.send(2'h2, 12'h101, 12'h101, 5);
        hold(4);
        wb(8'h0C, 1'h0, 32'h0);
        chk("pool hi", {28'h0, rd[9:6]}, 32'h0000_0002);
        see("one pool", 9'h00F, 9'h000, 1);
        dst_plant_inst.send(2'h3, 12'h101, 12'h101, 4);
        see("pool trip", 9'h07F, 9'h04F, 20);
        dst_plant_inst.send(2'h1, 12'h000, 12'h000, 0);
        dst_plant_inst.send(2'h3, 12'h000, 12'h000, 0);
        recover();
        $display("done pool");
    endtask

    initial begin
        hold(3);
        sys_rst <= 1'h0;
        see("power up", 9'h030, 9'h030, 30);
        hold(12);
        hbyp <= 4'h0;
        t_regs();
        t_stop();
        t_cv();
        t_bus();
        t_man();
        t_pool();
        test_done();
    end

    initial begin
        #400000;
        err_count++;
        test_done();
    end
endmodule // dst_top_tb
`default_nettype wire
